// ==== fsport_defs.svh ====
/*
  Constants for the framed serial port: word length, divider defaults and reset values.
  Assumes inclusion by the package and the port module only.
*/
`ifndef FSPORT_DEFS_SVH
`define FSPORT_DEFS_SVH
`define FSP_WORD_BITS      16
`define FSP_MCLK_DIV_DEF   8'h01
`define FSP_SCLK_DIV_DEF   8'h04
`define FSP_WORD_RESET     16'h0000
`define FSP_BITCNT_RESET   5'h00
`define FSP_DIVCNT_RESET   16'h0000
`endif

// ==== fsport_pkg.sv ====
/*
  Types shared by the framed serial port files.
  Assumes fsport_defs.svh is on the include path.
*/
`include "fsport_defs.svh"
package fsport_pkg;
  typedef logic [`FSP_WORD_BITS-1:0] word_t;
  typedef enum logic [1:0] {TX_IDLE, TX_SYNC, TX_SHIFT} txState_t;
  typedef struct packed {
    logic data;
    logic dataOe;
    logic sync;
    logic syncOe;
  } serialPins_t;
endpackage : fsport_pkg

// ==== sync2.sv ====
/*
  Two-flop synchroniser for one level arriving from outside the clock domain.
  Assumes an asynchronous active-low reset; reset value is a parameter.
*/
`timescale 1ns/1ps
module sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic sys_clk,   // system clock
  input  wire logic rst_n,     // asynchronous reset, active low
  input  wire logic asyncIn,   // level from outside the domain
  output logic      syncOut    // synchronised level
);
  logic stage1_r;
  logic stage1_nxt;
  logic syncOut_nxt;

  always_comb begin
    stage1_nxt  = asyncIn;
    syncOut_nxt = stage1_r;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= RESET_VAL;
      syncOut  <= RESET_VAL;
    end else begin
      stage1_r <= stage1_nxt;
      syncOut  <= syncOut_nxt;
    end
  end
endmodule : sync2

// ==== framed_serial_port.sv ====
/*
  Framed serial port of the converter: makes the serial clock from the master clock, sends
  framed 16-bit words and receives framed 16-bit words from the host.
  Assumes sys_clk is the master clock, supplied from outside; the pins of the host side
  are asynchronous and are synchronised here.
*/
// How it works
// - Active-low chip reset clears all internal logic; the divider settings are inputs and are not held here.
// - Port makes the serial clock itself and drives it out.
// - Serial clock equals master clock divided by master divider times serial divider, or by 2 when that product is 1.
// - Outgoing bits change on rising serial-clock edges, data and frame sync alike.
// - Data output floats when idle or when port enable is low.
// - Output frame sync is one serial period, just before the MSB.
// - Output frame sync changes on rising edges, floats while disabled.
// - Input frame sync sampled on falling edges, ignored while disabled.
// - Input bits captured MSB first, one per falling edge, after the sync.
// - Data input ignored completely while port enable is low.
// - Port disable floats outputs, ignores inputs, stops serial clock.
// - Re-enable keeps data registers; counters restart from reset values.
`timescale 1ns/1ps
module framed_serial_port
  import fsport_pkg::*;
#(
  parameter int WORD_BITS = `FSP_WORD_BITS,
  parameter int DIV_W     = 8
) (
  input  wire logic             sys_clk,          // master clock from outside
  input  wire logic             rst_n,            // chip reset, active low
  input  wire logic             port_enable_in,   // asynchronous port enable pin
  input  wire logic [DIV_W-1:0] mclkDiv,          // master clock rate divider, 0 reads as 1
  input  wire logic [DIV_W-1:0] sclkDiv,          // serial clock rate divider, 0 reads as 1
  input  wire logic             in_frame_sync,    // host frame sync pin
  input  wire logic             serial_data_in,   // host data pin
  input  wire logic             txValid,          // a word is offered for sending
  input  wire word_t            txWord,           // word to send
  output logic                  txReady,          // word taken this cycle
  output logic                  serialClk,        // serial clock pin
  output logic                  serial_data_out,  // data pin level
  output logic                  serialDataOe,     // data pin driven
  output logic                  out_frame_sync,   // frame sync pin level
  output logic                  outSyncOe,        // frame sync pin driven
  output logic                  rxValid,          // one-cycle pulse, word received
  output word_t                 rxWord            // last received word
);
  localparam int CNT_W = 2 * DIV_W;
  localparam int BIT_W = $clog2(WORD_BITS + 1);

  logic                       enSync;
  logic                       fsSync;
  logic                       sdSync;
  logic [CNT_W-1:0]           periodLen;
  logic [CNT_W-1:0]           highLen;
  logic [CNT_W-1:0]           divCnt_r, divCnt_nxt;
  logic                       serialClk_nxt;
  logic                       riseEv, fallEv;
  txState_t                   txState_r, txState_nxt;
  logic [BIT_W-1:0]           txBit_r, txBit_nxt;
  word_t                      txShift_r, txShift_nxt;
  logic                       txReady_nxt;
  serialPins_t                pins_nxt;
  logic                       rxArmed_r, rxArmed_nxt;
  logic [BIT_W-1:0]           rxBit_r, rxBit_nxt;
  word_t                      rxShift_r, rxShift_nxt;
  word_t                      rxWord_nxt;
  logic                       rxValid_nxt;

  // Enable and host pins are asynchronous, so each crosses two flops first.
  sync2 #(.RESET_VAL(1'b0)) uEnSync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .asyncIn (port_enable_in),
    .syncOut (enSync)
  );
  sync2 #(.RESET_VAL(1'b0)) uFsSync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .asyncIn (in_frame_sync),
    .syncOut (fsSync)
  );
  sync2 #(.RESET_VAL(1'b0)) uSdSync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .asyncIn (serial_data_in),
    .syncOut (sdSync)
  );

  // One serial period is the divider product in master clocks, and the high phase takes the odd cycle.
  // A product of 1 would need the serial clock to equal the master clock, so it runs as 2.
  // Receiving needs a high phase of at least three master clocks because of the input synchronisers.
  always_comb begin
    periodLen = CNT_W'((mclkDiv == '0 ? DIV_W'(1) : mclkDiv) *
                       (sclkDiv == '0 ? DIV_W'(1) : sclkDiv));
    if (periodLen < CNT_W'(2)) begin
      periodLen = CNT_W'(2);
    end
    highLen = periodLen - (periodLen >> 1);
  end

  // Serial clock generator, held still while the port is disabled.
  always_comb begin
    divCnt_nxt    = divCnt_r;
    serialClk_nxt = serialClk;
    riseEv        = 1'b0;
    fallEv        = 1'b0;
    if (!enSync) begin
      divCnt_nxt    = `FSP_DIVCNT_RESET;
      serialClk_nxt = 1'b0;
    end else if (divCnt_r + CNT_W'(1) >= periodLen) begin
      divCnt_nxt    = `FSP_DIVCNT_RESET;
      serialClk_nxt = 1'b1;
      riseEv        = 1'b1;
    end else begin
      divCnt_nxt = divCnt_r + CNT_W'(1);
      if (serialClk && (divCnt_r + CNT_W'(1) == highLen)) begin
        serialClk_nxt = 1'b0;
        fallEv        = 1'b1;
      end
    end
  end

  // Transmit side: sync period, then sixteen bits MSB first, all launched at rising edges.
  always_comb begin
    txState_nxt = txState_r;
    txBit_nxt   = txBit_r;
    txShift_nxt = txShift_r;
    txReady_nxt = 1'b0;
    pins_nxt    = '{data: serial_data_out, dataOe: serialDataOe,
                    sync: out_frame_sync, syncOe: outSyncOe};
    if (!enSync) begin
      txState_nxt = TX_IDLE;
      txBit_nxt   = `FSP_BITCNT_RESET;
      pins_nxt    = '{data: 1'b0, dataOe: 1'b0, sync: 1'b0, syncOe: 1'b0};
    end else if (riseEv) begin
      pins_nxt.syncOe = 1'b1;
      case (txState_r)
        TX_IDLE: begin
          pins_nxt.sync   = 1'b0;
          pins_nxt.dataOe = 1'b0;
          if (txValid) begin
            txShift_nxt   = txWord;
            txReady_nxt   = 1'b1;
            pins_nxt.sync = 1'b1;
            txState_nxt   = TX_SYNC;
          end
        end
        TX_SYNC, TX_SHIFT: begin
          pins_nxt.sync   = 1'b0;
          pins_nxt.data   = txShift_r[WORD_BITS-1];
          pins_nxt.dataOe = 1'b1;
          txShift_nxt     = {txShift_r[WORD_BITS-2:0], 1'b0};
          if (txBit_r == BIT_W'(WORD_BITS - 1)) begin
            txBit_nxt   = `FSP_BITCNT_RESET;
            txState_nxt = TX_IDLE;
          end else begin
            txBit_nxt   = txBit_r + BIT_W'(1);
            txState_nxt = TX_SHIFT;
          end
        end
        default: txState_nxt = TX_IDLE;
      endcase
    end
  end

  // Receive side: sample on falling edges; a sync arms a sixteen-bit capture.
  always_comb begin
    rxArmed_nxt = rxArmed_r;
    rxBit_nxt   = rxBit_r;
    rxShift_nxt = rxShift_r;
    rxWord_nxt  = rxWord;
    rxValid_nxt = 1'b0;
    if (!enSync) begin
      rxArmed_nxt = 1'b0;
      rxBit_nxt   = `FSP_BITCNT_RESET;
    end else if (fallEv) begin
      if (rxArmed_r) begin
        rxShift_nxt = {rxShift_r[WORD_BITS-2:0], sdSync};
        if (rxBit_r == BIT_W'(WORD_BITS - 1)) begin
          rxWord_nxt  = {rxShift_r[WORD_BITS-2:0], sdSync};
          rxValid_nxt = 1'b1;
          rxBit_nxt   = `FSP_BITCNT_RESET;
          rxArmed_nxt = fsSync;
        end else begin
          rxBit_nxt = rxBit_r + BIT_W'(1);
        end
      end else if (fsSync) begin
        rxArmed_nxt = 1'b1;
        rxBit_nxt   = `FSP_BITCNT_RESET;
      end
    end
  end

  // Reset clears everything, including the word registers that survive a port disable.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_r        <= `FSP_DIVCNT_RESET;
      serialClk       <= 1'b0;
      txState_r       <= TX_IDLE;
      txBit_r         <= `FSP_BITCNT_RESET;
      txShift_r       <= `FSP_WORD_RESET;
      txReady         <= 1'b0;
      serial_data_out <= 1'b0;
      serialDataOe    <= 1'b0;
      out_frame_sync  <= 1'b0;
      outSyncOe       <= 1'b0;
      rxArmed_r       <= 1'b0;
      rxBit_r         <= `FSP_BITCNT_RESET;
      rxShift_r       <= `FSP_WORD_RESET;
      rxWord          <= `FSP_WORD_RESET;
      rxValid         <= 1'b0;
    end else begin
      divCnt_r        <= divCnt_nxt;
      serialClk       <= serialClk_nxt;
      txState_r       <= txState_nxt;
      txBit_r         <= txBit_nxt;
      txShift_r       <= txShift_nxt;
      txReady         <= txReady_nxt;
      serial_data_out <= pins_nxt.data;
      serialDataOe    <= pins_nxt.dataOe;
      out_frame_sync  <= pins_nxt.sync;
      outSyncOe       <= pins_nxt.syncOe;
      rxArmed_r       <= rxArmed_nxt;
      rxBit_r         <= rxBit_nxt;
      rxShift_r       <= rxShift_nxt;
      rxWord          <= rxWord_nxt;
      rxValid         <= rxValid_nxt;
    end
  end
endmodule : framed_serial_port

// ==== fsp_sva.sv ====
/*
  Checker for the framed serial port pins, bound to the port module.
  Assumes the dividers change only while the port is disabled.
*/
`timescale 1ns/1ps
module fsp_sva
  import fsport_pkg::*;
#(
  parameter int DIV_W = 8
) (
  input wire logic             sys_clk,         // clock
  input wire logic             rst_n,           // reset
  input wire logic             port_enable_in,  // enable
  input wire logic [DIV_W-1:0] mclkDiv,         // master divider
  input wire logic [DIV_W-1:0] sclkDiv,         // serial divider
  input wire logic             txReady,         // word taken
  input wire logic             serialClk,       // serial clock
  input wire logic             serial_data_out, // data
  input wire logic             serialDataOe,    // data driven
  input wire logic             out_frame_sync,  // sync
  input wire logic             outSyncOe,       // sync driven
  input wire logic             rxValid,         // word in
  input wire word_t            rxWord           // received word
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] prod;
  logic [15:0] per;
  logic [15:0] hi;
  logic        prevClk_r;
  logic [7:0]  clkCnt_r;
  logic [15:0] syncCnt_r;
  assign prod = ((mclkDiv == '0) ? 16'h0001 : 16'(mclkDiv)) * ((sclkDiv == '0) ? 16'h0001 : 16'(sclkDiv));
  assign per  = (prod < 16'h0002) ? 16'h0002 : prod;
  assign hi   = per - (per >> 1);
  // The clock counter saturates, so a clock stopped by a disable is never judged.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevClk_r <= 1'b0;
      clkCnt_r  <= 8'hff;
      syncCnt_r <= 16'h0000;
    end else begin
      prevClk_r <= serialClk;
      clkCnt_r  <= (serialClk != prevClk_r) ? 8'h01 : clkCnt_r + {7'h00, clkCnt_r != 8'hff};
      syncCnt_r <= out_frame_sync ? syncCnt_r + 16'h0001 : 16'h0000;
    end
  end
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> !(serialClk | serialDataOe | outSyncOe | txReady | rxValid))
    else $error("outputs active in reset");
  a_disable_float: assert property (!port_enable_in [*5] |-> !(serialClk | serialDataOe | outSyncOe | rxValid))
    else $error("port active while disabled");
  a_ready_rise: assert property (txReady |-> $rose(serialClk) && out_frame_sync && outSyncOe)
    else $error("word taken off a rising serial edge");
  a_sync_width: assert property ($fell(out_frame_sync) && outSyncOe |-> syncCnt_r == per)
    else $error("frame sync not one serial period");
  a_msb_follows: assert property ($fell(out_frame_sync) && outSyncOe |-> serialDataOe && $rose(serialClk))
    else $error("MSB does not follow frame sync");
  a_data_rise: assert property (serialDataOe && $past(serialDataOe) && $changed(serial_data_out) |-> $rose(serialClk))
    else $error("data changed off a rising edge");
  a_oe_sync: assert property ($rose(serialDataOe) |-> $fell(out_frame_sync))
    else $error("data driven outside a frame");
  a_clk_period: assert property (disable iff (!rst_n || !port_enable_in)
    serialClk != prevClk_r && clkCnt_r != 8'hff |-> {8'h00, clkCnt_r} == (prevClk_r ? hi : per - hi))
    else $error("serial clock half period wrong");
  a_rx_hold: assert property ($changed(rxWord) |-> rxValid)
    else $error("received word changed without pulse");
endmodule : fsp_sva

bind framed_serial_port fsp_sva #(.DIV_W(DIV_W)) chk_u (.sys_clk, .rst_n, .port_enable_in, .mclkDiv, .sclkDiv,
  .txReady, .serialClk, .serial_data_out, .serialDataOe, .out_frame_sync, .outSyncOe, .rxValid, .rxWord);

// ==== host_framed_serial_port_model.sv ====
/*
  Host end of the serial link: sends framed words on request and captures the port's words.
  Assumes the port's serial clock is its only timing reference.
*/
`timescale 1ns/1ps
module host_link_model
  import fsport_pkg::*;
(
  input  wire logic  serialClk,       // serial clock from the port
  input  wire logic  serial_data_out, // port data pin level
  input  wire logic  out_frame_sync,  // port sync pin level
  input  wire logic  sendReq,         // a word is wanted
  input  wire word_t sendWord,        // word to send
  output logic       in_frame_sync,   // sync to the port
  output logic       serial_data_in,  // data to the port
  output word_t      gotWord,         // last captured word
  output int         gotCount,        // words captured
  output int         sentCount        // words started
);
  word_t shiftOut;
  word_t shiftIn;
  int    txBit;
  int    rxBit;
  initial begin
    {in_frame_sync, serial_data_in, gotWord, gotCount, sentCount, txBit, rxBit} = '0;
  end
  always @(posedge serialClk) begin
    if (txBit > 0) begin
      in_frame_sync <= 1'b0;
      serial_data_in <= shiftOut[15];
      shiftOut <= shiftOut << 1;
      txBit <= txBit - 1;
    end else begin
      // Outside a word the data line toggles, so a stale bit can never pass for a real one.
      in_frame_sync <= sendReq;
      serial_data_in <= ~serial_data_in;
      shiftOut <= sendWord;
      txBit <= sendReq ? 16 : 0;
      sentCount <= sentCount + int'(sendReq);
    end
  end
  always @(negedge serialClk) begin
    if (rxBit > 0) begin
      shiftIn = {shiftIn[14:0], serial_data_out};
      rxBit <= rxBit - 1;
      gotWord <= (rxBit == 1) ? shiftIn : gotWord;
      gotCount <= gotCount + int'(rxBit == 1);
    end
    if (out_frame_sync === 1'b1) rxBit <= 16;
  end
endmodule : host_link_model

// ==== adc_frame_sync_serial_port_tb.sv ====
/*
  Self-checking bench: random words both ways over random divider settings.
  Assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module adc_frame_sync_serial_port_tb;
  import fsport_pkg::*;
  localparam int LIM = 4000;
  logic  sys_clk = 1'b0;
  logic  rst_n;
  logic  port_enable_in = 1'b1;
  logic  [7:0] mclkDiv = 8'h01;
  logic  [7:0] sclkDiv = 8'h04;
  logic  txValid = 1'b0;
  word_t txWord = 16'h0000;
  logic  sendReq = 1'b0;
  word_t sendWord = 16'h0000;
  logic  txReady, serialClk, serial_data_out, serialDataOe, out_frame_sync, outSyncOe, rxValid;
  logic  in_frame_sync, serial_data_in;
  word_t rxWord, gotWord;
  int    gotCount, sentCount, badCount = 0, numChecks = 0;
  logic  [31:0] seed = 32'h09b2;
  wire   dataPin = serialDataOe ? serial_data_out : 1'bz;
  wire   syncPin = outSyncOe ? out_frame_sync : 1'bz;
  always #4 sys_clk = ~sys_clk;
  framed_serial_port dut_u (.sys_clk, .rst_n, .port_enable_in, .mclkDiv, .sclkDiv, .in_frame_sync,
    .serial_data_in, .txValid, .txWord, .txReady, .serialClk, .serial_data_out, .serialDataOe,
    .out_frame_sync, .outSyncOe, .rxValid, .rxWord);
  host_link_model host_u (.serialClk, .serial_data_out(dataPin), .out_frame_sync(syncPin), .sendReq,
    .sendWord, .in_frame_sync, .serial_data_in, .gotWord, .gotCount, .sentCount);
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic check(input word_t got, input word_t exp);
    numChecks++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic guard(input int n);
    if (n >= LIM) begin
      badCount++;
      $display("MISMATCH %0t wait timed out", $time);
      summarize();
    end
  endtask : guard
  initial begin
    int n;
    int c;
    word_t w[2];
    // Reset falls from unknown at time zero, so the asynchronous reset branches really fire.
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    for (int it = 0; it < 5; it++) begin
      seed = xs(seed);
      // Dividers only change with the port parked, so the clock never glitches mid-word.
      port_enable_in <= 1'b0;
      repeat (300) @(posedge sys_clk);
      mclkDiv <= (it == 0) ? 8'h00 : 8'h01 + {7'h00, seed[0]};
      sclkDiv <= 8'h05 + {7'h00, seed[1]};
      port_enable_in <= 1'b1;
      w[0] = (it == 1) ? 16'hffff : seed[31:16];
      w[1] = (it == 1) ? 16'h0000 : seed[15:0];
      c = gotCount;
      for (int k = 0; k < 2; k++) begin
        txWord <= w[k];
        txValid <= 1'b1;
        n = 0;
        do @(posedge sys_clk); while (txReady !== 1'b1 && ++n < LIM);
        guard(n);
      end
      txValid <= 1'b0;
      check(gotWord, w[0]);
      n = 0;
      do @(posedge sys_clk); while (gotCount < c + 2 && ++n < LIM);
      guard(n);
      check(gotWord, w[1]);
      sendWord <= (it == 2) ? 16'h8001 : seed[23:8];
      sendReq <= 1'b1;
      c = sentCount;
      n = 0;
      do @(posedge sys_clk); while (sentCount == c && ++n < LIM);
      guard(n);
      sendReq <= 1'b0;
      n = 0;
      do @(posedge sys_clk); while (rxValid !== 1'b1 && ++n < LIM);
      guard(n);
      check(rxWord, (it == 2) ? 16'h8001 : seed[23:8]);
    end
    summarize();
  end
endmodule : adc_frame_sync_serial_port_tb
